// >>> logic/ssc_pkg.sv
// constants and types for the section sample/store capture path
package ssc_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int unsigned SSC_GRP_W    = 16;
  localparam int unsigned SSC_NGRP     = 6;
  localparam int unsigned SSC_NSEC     = 3;
  localparam int unsigned SSC_LVL_W    = 4;
  localparam int unsigned SSC_MEM_D    = 512;
  localparam int unsigned SSC_ADR_W    = 9;
  localparam int unsigned SSC_SEC_W    = 2 * SSC_GRP_W;
  localparam int unsigned SSC_WORD_W   = SSC_SEC_W * SSC_NSEC + SSC_LVL_W;
  localparam logic [SSC_ADR_W-1:0] SSC_ADR_LAST = 9'h1FF;
  localparam logic [SSC_ADR_W-1:0] SSC_ADR_ZERO = 9'h000;
  localparam logic [SSC_LVL_W-1:0] SSC_LVL_ZERO = 4'h0;
  localparam logic [SSC_LVL_W-1:0] SSC_LVL_MAX  = 4'hF;
  // ----------------------------------------
  // recording states
  // ----------------------------------------
  typedef enum logic [1:0] {
    SSC_IDLE,
    SSC_RUN,
    SSC_XFER
  } ssc_rec_t;
endpackage : ssc_pkg

// >>> logic/ssc_group.sv
// one 16-input sample group with its own clock select and edge capture
`timescale 1ns/1ps
`default_nettype none
module ssc_group
  import ssc_pkg::*;
(
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 clk_sel_ext_in,
  input  wire logic                 int_clk_in,
  input  wire logic                 ext_clk_in,
  input  wire logic [SSC_GRP_W-1:0] data_in,
  output var  logic [SSC_GRP_W-1:0] sample_out,
  output var  logic                 strobe_out
);
  logic                 clk_q;
  logic                 clk_d;
  logic [SSC_GRP_W-1:0] sample_q;
  logic [SSC_GRP_W-1:0] sample_d;
  logic                 strobe_d;
  logic                 edge_w;

  // ----------------------------------------
  // clock pick and capture
  // ----------------------------------------
  always_comb begin
    clk_d    = clk_sel_ext_in ? ext_clk_in : int_clk_in;
    edge_w   = clk_d & ~clk_q;
    sample_d = edge_w ? data_in : sample_q;
    strobe_d = edge_w;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_q      <= 1'b0;
      sample_q   <= '0;
      strobe_out <= 1'b0;
    end else begin
      clk_q      <= clk_d;
      sample_q   <= sample_d;
      strobe_out <= strobe_d;
    end
  end

  assign sample_out = sample_q;
endmodule : ssc_group
`default_nettype wire

// >>> logic/ssc_capture.sv
// section sample/store capture top: groups, write rate, record control
`timescale 1ns/1ps
`default_nettype none
module ssc_capture
  import ssc_pkg::*;
(
  input  wire logic                              sys_clk_in,
  input  wire logic                              rst_n_in,
  input  wire logic [SSC_NGRP-1:0]               grp_ext_sel_in,
  input  wire logic [SSC_NGRP-1:0]               grp_int_clk_in,
  input  wire logic [SSC_NGRP-1:0]               grp_ext_clk_in,
  input  wire logic [SSC_NGRP*SSC_GRP_W-1:0]     probe_data_in,
  input  wire logic                              master_clk_in,
  input  wire logic [SSC_NSEC-1:0]               store_mode_in,
  input  wire logic [SSC_NSEC-1:0]               store_clk_in,
  input  wire logic [SSC_NSEC-1:0]               mem_write_en_in,
  input  wire logic                              trace_enable_in,
  input  wire logic                              rec_start_in,
  input  wire logic                              rec_advance_in,
  input  wire logic                              rec_stop_in,
  input  wire logic                              rec_xfer_in,
  input  wire logic [SSC_ADR_W-1:0]              rd_addr_in,
  output var  logic [SSC_NGRP*SSC_GRP_W-1:0]     trace_data_out,
  output var  logic                              trace_valid_out,
  output var  logic [SSC_NSEC*SSC_SEC_W-1:0]     rd_data_out,
  output var  logic [SSC_LVL_W-1:0]              rd_level_out,
  output var  logic [SSC_NSEC*SSC_ADR_W-1:0]     sec_count_out,
  output var  logic                              split_timing_out,
  output var  logic                              recording_out,
  output var  logic                              xfer_busy_out,
  output var  logic [SSC_ADR_W-1:0]              xfer_addr_out,
  output var  logic [SSC_LVL_W-1:0]              trace_level_out
);
  logic [SSC_NGRP*SSC_GRP_W-1:0] smp_w;
  logic [SSC_NGRP-1:0]           stb_w;
  logic                          mclk_q;
  logic                          mclk_edge_w;
  logic [SSC_NSEC-1:0]           sclk_q;
  logic [SSC_NSEC-1:0]           sec_wr_w;

  // per-section memory keeps independent write pointers for split timing
  logic [SSC_SEC_W-1:0] mem_a [SSC_MEM_D];
  logic [SSC_SEC_W-1:0] mem_b [SSC_MEM_D];
  logic [SSC_SEC_W-1:0] mem_c [SSC_MEM_D];
  logic [SSC_LVL_W-1:0] mem_l [SSC_MEM_D];

  ssc_rec_t                      st_q,   st_d;
  logic [SSC_ADR_W-1:0]          ptr_q   [SSC_NSEC];
  logic [SSC_ADR_W-1:0]          ptr_d   [SSC_NSEC];
  logic [SSC_LVL_W-1:0]          lvl_q,  lvl_d;
  logic [SSC_ADR_W-1:0]          xa_q,   xa_d;
  logic                          split_q, split_d;
  logic [SSC_NGRP*SSC_GRP_W-1:0] td_q,   td_d;
  logic                          tv_q,   tv_d;
  logic                          rec_q,  rec_d;
  logic                          busy_q, busy_d;
  logic [SSC_NSEC*SSC_SEC_W-1:0] rd_q;
  logic [SSC_LVL_W-1:0]          rl_q;
  logic                          wr_ok_w;

  // ----------------------------------------
  // input groups
  // ----------------------------------------
  for (genvar g = 0; g < SSC_NGRP; g++) begin : g_grp
    ssc_group u_grp (
      .sys_clk_in     (sys_clk_in),
      .rst_n_in       (rst_n_in),
      .clk_sel_ext_in (grp_ext_sel_in[g]),
      .int_clk_in     (grp_int_clk_in[g]),
      .ext_clk_in     (grp_ext_clk_in[g]),
      .data_in        (probe_data_in[g*SSC_GRP_W +: SSC_GRP_W]),
      .sample_out     (smp_w[g*SSC_GRP_W +: SSC_GRP_W]),
      .strobe_out     (stb_w[g])
    );
  end

  // ----------------------------------------
  // write rate select
  // ----------------------------------------
  always_comb begin
    mclk_edge_w = master_clk_in & ~mclk_q;
    // recording and tracing must both hold on the same edge
    wr_ok_w     = (st_q == SSC_RUN) && trace_enable_in;
    for (int s = 0; s < SSC_NSEC; s++) begin
      sec_wr_w[s] = wr_ok_w && mem_write_en_in[s] && (store_mode_in[s]
                    ? (store_clk_in[s] & ~sclk_q[s])
                    : mclk_edge_w);
    end
  end

  // ----------------------------------------
  // record control and pointers
  // ----------------------------------------
  always_comb begin
    st_d    = st_q;
    lvl_d   = lvl_q;
    xa_d    = xa_q;
    split_d = split_q;
    td_d    = td_q;
    tv_d    = mclk_edge_w;
    for (int s = 0; s < SSC_NSEC; s++) begin
      ptr_d[s] = sec_wr_w[s] ? ptr_q[s] + 1'b1 : ptr_q[s];
    end
    if (mclk_edge_w) begin
      td_d = smp_w;
    end
    // a write stepping only some of the enabled sections marks differing counts
    if ((sec_wr_w != '0) && (sec_wr_w != (mem_write_en_in & {SSC_NSEC{1'b1}}))) begin
      split_d = 1'b1;
    end
    case (st_q)
      SSC_IDLE: begin
        if (rec_start_in) begin
          st_d    = SSC_RUN;
          lvl_d   = SSC_LVL_ZERO;
          split_d = 1'b0;
          for (int s = 0; s < SSC_NSEC; s++) begin
            ptr_d[s] = SSC_ADR_ZERO;
          end
        end else if (rec_xfer_in) begin
          st_d = SSC_XFER;
          xa_d = SSC_ADR_ZERO;
        end
      end
      SSC_RUN: begin
        if (rec_stop_in) begin
          st_d = SSC_IDLE;
        end else if (rec_advance_in && lvl_q != SSC_LVL_MAX) begin
          lvl_d = lvl_q + 1'b1;
        end
      end
      SSC_XFER: begin
        xa_d = xa_q + 1'b1;
        if (xa_q == SSC_ADR_LAST) begin
          st_d = SSC_IDLE;
        end
      end
      default: st_d = SSC_IDLE;
    endcase
    // status flags registered so the outputs come from flops
    rec_d  = (st_d == SSC_RUN);
    busy_d = (st_d == SSC_XFER);
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q    <= SSC_IDLE;
      lvl_q   <= SSC_LVL_ZERO;
      xa_q    <= SSC_ADR_ZERO;
      split_q <= 1'b0;
      td_q    <= '0;
      tv_q    <= 1'b0;
      rec_q   <= 1'b0;
      busy_q  <= 1'b0;
      mclk_q  <= 1'b0;
      sclk_q  <= '0;
      for (int s = 0; s < SSC_NSEC; s++) begin
        ptr_q[s] <= SSC_ADR_ZERO;
      end
    end else begin
      st_q    <= st_d;
      lvl_q   <= lvl_d;
      xa_q    <= xa_d;
      split_q <= split_d;
      td_q    <= td_d;
      tv_q    <= tv_d;
      rec_q   <= rec_d;
      busy_q  <= busy_d;
      mclk_q  <= master_clk_in;
      sclk_q  <= store_clk_in;
      for (int s = 0; s < SSC_NSEC; s++) begin
        ptr_q[s] <= ptr_d[s];
      end
    end
  end

  // ----------------------------------------
  // acquisition memory
  // ----------------------------------------
  // no reset on the arrays: contents are only valid up to each pointer
  always_ff @(posedge sys_clk_in) begin
    if (sec_wr_w[0]) begin
      mem_a[ptr_q[0]] <= smp_w[0 +: SSC_SEC_W];
      mem_l[ptr_q[0]] <= lvl_q;
    end
    if (sec_wr_w[1]) begin
      mem_b[ptr_q[1]] <= smp_w[SSC_SEC_W +: SSC_SEC_W];
    end
    if (sec_wr_w[2]) begin
      mem_c[ptr_q[2]] <= smp_w[2*SSC_SEC_W +: SSC_SEC_W];
    end
  end

  // read port follows transfer address while copying out
  always_ff @(posedge sys_clk_in) begin
    rd_q <= (st_q == SSC_XFER)
          ? {mem_c[xa_q], mem_b[xa_q], mem_a[xa_q]}
          : {mem_c[rd_addr_in], mem_b[rd_addr_in], mem_a[rd_addr_in]};
    rl_q <= (st_q == SSC_XFER) ? mem_l[xa_q] : mem_l[rd_addr_in];
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign trace_data_out   = td_q;
  assign trace_valid_out  = tv_q;
  assign rd_data_out      = rd_q;
  assign rd_level_out     = rl_q;
  assign sec_count_out    = {ptr_q[2], ptr_q[1], ptr_q[0]};
  assign split_timing_out = split_q;
  assign recording_out    = rec_q;
  assign xfer_busy_out    = busy_q;
  assign xfer_addr_out    = xa_q;
  assign trace_level_out  = lvl_q;
endmodule : ssc_capture
`default_nettype wire

// >>> tb/ssc_capture_chk.sv
// port assertions for the capture path
`timescale 1ns/1ps
`default_nettype none
module ssc_capture_chk
  import ssc_pkg::*;
(
  input wire logic                          sys_clk_in,
  input wire logic                          rst_n_in,
  input wire logic                          master_clk_in,
  input wire logic                          trace_enable_in,
  input wire logic                          rec_start_in,
  input wire logic                          rec_advance_in,
  input wire logic                          rec_stop_in,
  input wire logic                          trace_valid_out,
  input wire logic [SSC_NSEC*SSC_ADR_W-1:0] sec_count_out,
  input wire logic                          split_timing_out,
  input wire logic                          recording_out,
  input wire logic                          xfer_busy_out,
  input wire logic [SSC_ADR_W-1:0]          xfer_addr_out,
  input wire logic [SSC_LVL_W-1:0]          trace_level_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  a_trace_tick: assert property ($rose(master_clk_in) |-> ##[1:3] trace_valid_out)
    else $error("no trace pulse");
  a_valid_one: assert property (trace_valid_out |=> !trace_valid_out)
    else $error("trace pulse long");
  a_off_no_write: assert property ((!trace_enable_in && !rec_start_in)[*3] |=> $stable(sec_count_out))
    else $error("write while off");
  a_stop_idle: assert property (recording_out && rec_stop_in |=> !recording_out)
    else $error("stop ignored");
  a_start_clear: assert property (!recording_out && !xfer_busy_out && rec_start_in
    |=> recording_out && sec_count_out == '0 && !split_timing_out) else $error("start bad");
  a_adv_step: assert property (recording_out && rec_advance_in && !rec_stop_in && trace_level_out != 4'hF
    |=> trace_level_out == $past(trace_level_out) + 4'h1) else $error("advance bad");
  a_adv_sat: assert property (recording_out && trace_level_out == 4'hF |=> trace_level_out == 4'hF)
    else $error("level wrapped");
  a_xfer_walk: assert property (xfer_busy_out && xfer_addr_out != 9'h1FF
    |=> xfer_busy_out && xfer_addr_out == $past(xfer_addr_out) + 9'h001) else $error("xfer step");
  a_xfer_end: assert property (xfer_busy_out && xfer_addr_out == 9'h1FF |=> !xfer_busy_out)
    else $error("xfer overrun");
  a_split_run: assert property ($rose(split_timing_out) |-> $past(recording_out))
    else $error("split outside run");
  c_trace: cover property (trace_valid_out);
  c_split: cover property ($rose(split_timing_out));
  c_xfer: cover property ($fell(xfer_busy_out));
endmodule : ssc_capture_chk
bind ssc_capture ssc_capture_chk i_ssc_capture_chk (.sys_clk_in, .rst_n_in, .master_clk_in, .trace_enable_in,
  .rec_start_in, .rec_advance_in, .rec_stop_in, .trace_valid_out, .sec_count_out, .split_timing_out,
  .recording_out, .xfer_busy_out, .xfer_addr_out, .trace_level_out);
`default_nettype wire

// >>> tb/ssc_target.sv
// target model: probe data and clocks
`timescale 1ns/1ps
`default_nettype none
module ssc_target
  import ssc_pkg::*;
(
  input  wire logic                          sys_clk_in,
  input  wire logic                          run_in,
  input  wire logic [SSC_GRP_W-1:0]          pat_in,
  output var  logic                          mclk_out,
  output var  logic                          sclk_out,
  output var  logic [SSC_NGRP*SSC_GRP_W-1:0] data_out
);
  logic [7:0] cnt_q;
  // clocks stand still low between runs, so no stray edge
  always_ff @(posedge sys_clk_in) cnt_q <= run_in ? cnt_q + 8'h01 : 8'h00;
  assign mclk_out = cnt_q[2];
  assign sclk_out = cnt_q[1];
  assign data_out = {SSC_NGRP{pat_in}};
endmodule : ssc_target
`default_nettype wire

// >>> tb/tb_ssc_capture.sv
// testbench for the capture path
`timescale 1ns/1ps
`default_nettype none
module tb_ssc_capture;
  import ssc_pkg::*;
  typedef struct packed {logic [2:0] md; logic [2:0] en; logic [26:0] cnt; logic spl;} ssc_row_t;
  logic sys_clk_in = 0, rst_n_in = 0, master_clk_in, sclk, run = 0, trace_enable_in = 0, xclk = 0;
  logic rec_start_in = 0, rec_advance_in = 0, rec_stop_in = 0, rec_xfer_in = 0;
  logic [5:0] grp_ext_sel_in = 6'h00;
  logic [2:0] store_mode_in = 3'h0, mem_write_en_in = 3'h0;
  logic [15:0] pat = 16'hA5C3;
  logic [8:0] rd_addr_in = 9'h000, xfer_addr_out;
  logic [95:0] probe_data_in, trace_data_out, rd_data_out;
  logic [26:0] sec_count_out;
  logic [3:0] rd_level_out, trace_level_out;
  logic trace_valid_out, split_timing_out, recording_out, xfer_busy_out;
  int errors = 0, n_compared = 0, cyc = 0, k;
  // master 3 ticks, store 6 ticks per run
  ssc_row_t rows [5] = '{'{3'h0, 3'h7, {9'h003, 9'h003, 9'h003}, 1'b0}, '{3'h4, 3'h7, {9'h006, 9'h003, 9'h003}, 1'b1},
    '{3'h7, 3'h7, {9'h006, 9'h006, 9'h006}, 1'b0}, '{3'h0, 3'h3, {9'h000, 9'h003, 9'h003}, 1'b0},
    '{3'h1, 3'h5, {9'h003, 9'h000, 9'h006}, 1'b1}};
  ssc_target i_ssc_target (.sys_clk_in, .run_in(run), .pat_in(pat), .mclk_out(master_clk_in), .sclk_out(sclk),
    .data_out(probe_data_in));
  ssc_capture i_ssc_capture (.sys_clk_in, .rst_n_in, .grp_ext_sel_in, .grp_int_clk_in({6{sclk}}),
    .grp_ext_clk_in({6{xclk}}), .probe_data_in, .master_clk_in, .store_mode_in, .store_clk_in({3{sclk}}),
    .mem_write_en_in, .trace_enable_in, .rec_start_in, .rec_advance_in, .rec_stop_in, .rec_xfer_in, .rd_addr_in,
    .trace_data_out, .trace_valid_out, .rd_data_out, .rd_level_out, .sec_count_out, .split_timing_out,
    .recording_out, .xfer_busy_out, .xfer_addr_out, .trace_level_out);
  initial begin
    forever #2 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  // one recording: start, run the target 24 cycles, stop
  task automatic rec(input logic [2:0] md, input logic [2:0] en, input logic t);
    @(posedge sys_clk_in);
    {store_mode_in, mem_write_en_in, trace_enable_in, rec_start_in} <= {md, en, t, 1'b1};
    @(posedge sys_clk_in);
    rec_start_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    run <= 1'b1;
    repeat (24) @(posedge sys_clk_in);
    run <= 1'b0;
    repeat (6) @(posedge sys_clk_in);
    rec_stop_in <= 1'b1;
    @(posedge sys_clk_in);
    rec_stop_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
  endtask : rec
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk_in);
    chk({recording_out, xfer_busy_out, split_timing_out, trace_valid_out, trace_level_out}, '0);
    rst_n_in <= 1'b1;
    foreach (rows[i]) begin
      rec(rows[i].md, rows[i].en, 1'b1);
      chk(sec_count_out, rows[i].cnt);
      chk(split_timing_out, rows[i].spl);
      $display("row %0d done", i);
    end
    rec(3'h1, 3'h7, 1'b0);
    chk(sec_count_out, '0);
    @(posedge sys_clk_in);
    pat <= 16'h3C5A;
    grp_ext_sel_in <= 6'h01;
    rec(3'h0, 3'h7, 1'b1);
    chk(trace_data_out, {{5{16'h3C5A}}, 16'hA5C3});
    @(posedge sys_clk_in);
    rd_addr_in <= 9'h001;
    repeat (3) @(posedge sys_clk_in);
    #1;
    chk(rd_data_out, {{5{16'h3C5A}}, 16'hA5C3});
    chk(rd_level_out, 4'h0);
    $display("capture test done");
    // groups 1..5 now take the external clock, group 0 the internal one
    grp_ext_sel_in <= 6'h3E;
    pat <= 16'h0FF0;
    @(posedge sys_clk_in);
    xclk <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    xclk <= 1'b0;
    pat <= 16'h1234;
    rec(3'h0, 3'h7, 1'b1);
    chk(trace_data_out, {{5{16'h0FF0}}, 16'h1234});
    $display("external clock test done");
    @(posedge sys_clk_in);
    rec_start_in <= 1'b1;
    @(posedge sys_clk_in);
    {rec_start_in, rec_advance_in} <= 2'h1;
    repeat (20) @(posedge sys_clk_in);
    {rec_advance_in, rec_stop_in} <= 2'h1;
    @(posedge sys_clk_in);
    rec_stop_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    chk({trace_level_out, recording_out}, {4'hF, 1'b0});
    $display("advance test done");
    @(posedge sys_clk_in);
    rec_xfer_in <= 1'b1;
    @(posedge sys_clk_in);
    rec_xfer_in <= 1'b0;
    k = 0;
    repeat (600) begin
      #1;
      if (xfer_busy_out === 1'b1) begin
        chk(xfer_addr_out, k);
        k++;
      end
      @(posedge sys_clk_in);
    end
    chk(k, 512);
    $display("transfer test done");
    wrap_up();
  end
endmodule : tb_ssc_capture
`default_nettype wire
